// File: pkg/ofs_pkg.sv
/*
 * Constants, types and register map of the output fault supervisor.
 * Assumes comparator results arrive synchronous to clk and that the
 * register master follows the plain strobe protocol.
 */
// Operation
// R1: Decode 4-bit short code: 75 mV steps, code 8 default 0.563 V, 0 top.
// R2: In limp-home use the default short threshold whatever code is stored.
// R3: Short threshold never depends on the analog dimming input.
// R4: Mask short and open-load detection until soft-start ramp reaches 1.75 V.
// R5: When a short has gone, restart regulation through soft start.
// R6: Feedback overvoltage sets its flag and stops gates in break-low.
// R7: Non-latched overvoltage resumes once feedback falls below hysteresis.
// R8: Overvoltage flag clears after the next read of the diagnosis word; here a latched OV flag survives the read.
// R9: With latch enabled, overvoltage stop holds until host writes clear-latch.
// R10: Open load needs feedback above level and current sense below reference.
// R11: Ignore open load while the soft-start ramp is still rising.
// R12: Open load sets its flag, stops in break-low, restarts via soft start.
// R13: Open-load flag clears after the next read of the diagnosis word.
// R14: Several fault flags may be set together, none masks another.
// R15: Discharge the compensation node while open load persists.
// R16: Input overvoltage sets its flag and discharges the soft-start cap.
// R17: After input overvoltage ends, restart through soft start.
// R18: Input OV and enable/UV inputs are hysteretic comparator results.
// R19: Short declared only after 8 consecutive cycles below threshold.
// R20: Short sets its flag and stops in break-low; read clears the flag.
// R21: Flags are registered and held until the clearing read; here a clear-latch write also clears the OV flag.
package ofs_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_MFS  = 8'h00;
	localparam logic [7:0] ADDR_SWT  = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_DIAG = 8'h0c;
	localparam logic [7:0] ADDR_STAT = 8'h10;

	localparam logic [3:0]  THR_CODE_RST = 4'h8;
	localparam logic [3:0]  THR_CODE_TOP = 4'h0;
	localparam logic [10:0] THR_BASE_MV  = 11'h026;
	localparam logic [10:0] THR_STEP_MV  = 11'h04b;
	localparam logic [10:0] THR_TOP_MV   = 11'h48b;
	localparam logic [10:0] THR_DEF_MV   = 11'h233;

	localparam int unsigned SHORT_CYC  = 8;
	localparam logic [2:0]  SHORT_LAST = 3'(SHORT_CYC - 1);

	localparam int unsigned DG_SHORT = 0;
	localparam int unsigned DG_OV    = 1;
	localparam int unsigned DG_OL    = 2;
	localparam int unsigned DG_VIN   = 3;
	localparam int unsigned DG_W     = 4;

	localparam int unsigned SWT_OVLAT  = 0;
	localparam int unsigned CTRL_CLEAR_LATCH_CONTROL = 0;

	localparam int unsigned STAT_BRK  = 0;
	localparam int unsigned STAT_LAT  = 1;
	localparam int unsigned STAT_SSD  = 2;
	localparam int unsigned STAT_LIMP = 3;
	localparam int unsigned STAT_DIM  = 8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic fb_below_short;
		logic fb_over_ov;
		logic fb_above_ol;
		logic cs_below_ol_ref;
		logic ss_ready;
		logic input_ov_sense;
		logic enable_uv_sense;
		logic limp_home;
	} ofs_sense_t;

	typedef struct packed {
		logic        break_low;
		logic        ss_discharge;
		logic        comp_discharge;
		logic [10:0] short_thr_mv;
	} ofs_drive_t;

	typedef enum logic [1:0] {
		st_idle,
		st_soft,
		st_run,
		st_stop
	} ofs_state_t;

endpackage

// File: hdl/ofs_supervisor.sv
/*
 * Output fault supervisor: short, output overvoltage, open load and
 * input overvoltage handling with diagnosis flags and registers.
 * Assumes synchronous comparator inputs with analog hysteresis and a
 * register master that never issues read and write together.
 */
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
module ofs_supervisor (
	input  wire logic              clk,        // 50 MHz clock
	input  wire logic              srst,       // Sync reset, active high
	input  wire logic              ce,         // Clock enable
	input  wire logic [7:0]        addr,       // Register byte address
	input  wire logic [31:0]       wdata,      // Write data
	input  wire logic              wr,         // Write strobe
	input  wire logic              rd,         // Read strobe
	output      logic [31:0]       rdata,      // Read data, next cycle
	input  wire ofs_pkg::ofs_sense_t sense,    // Comparator results
	input  wire logic [7:0]        analog_dim_input, // Dimming setting
	output      ofs_pkg::ofs_drive_t drive     // Power stage controls
);

	// ----------------------------------------------------------------
	// Threshold decode
	// ----------------------------------------------------------------
	function automatic logic [10:0] thr_mv(input logic [3:0] code);
		logic [10:0] steps;
		steps = {7'h00, code} - 11'h001;
		if (code == ofs_pkg::THR_CODE_TOP) begin
			thr_mv = ofs_pkg::THR_TOP_MV;
		end else begin
			thr_mv = 11'(ofs_pkg::THR_BASE_MV
				+ steps * ofs_pkg::THR_STEP_MV);
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [3:0]                 short_threshold_code_reg;
	logic [3:0]                 short_threshold_code_next;
	logic                       overvoltage_latch_enable_reg;
	logic                       overvoltage_latch_enable_next;
	logic [31:0]                rdata_reg;
	logic [31:0]                rdata_next;
	logic [2:0]                 short_cnt_reg;
	logic [2:0]                 short_cnt_next;
	logic [ofs_pkg::DG_W-1:0]   diag_reg;
	logic [ofs_pkg::DG_W-1:0]   diag_next;
	logic                       ov_latched_reg;
	logic                       ov_latched_next;
	ofs_pkg::ofs_state_t        state_reg;
	ofs_pkg::ofs_state_t        state_next;
	ofs_pkg::ofs_drive_t        drive_reg;
	ofs_pkg::ofs_drive_t        drive_next;

	logic                       rd_diag;
	logic                       clear_latch_control;
	logic                       short_cond;
	logic                       short_det;
	logic                       ol_raw;
	logic                       ol_det;
	logic                       ov_det;
	logic                       ov_hold;
	logic                       fault_now;
	logic                       release_ok;
	logic [ofs_pkg::DG_W-1:0]   set_vec;
	logic [31:0]                stat_word;

	assign rdata = rdata_reg;
	assign drive = drive_reg;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	assign rd_diag = rd && (addr == ofs_pkg::ADDR_DIAG);
	assign clear_latch_control = wr && (addr == ofs_pkg::ADDR_CTRL)
		&& wdata[ofs_pkg::CTRL_CLEAR_LATCH_CONTROL];

	always_comb begin
		stat_word = 32'h00000000;
		stat_word[ofs_pkg::STAT_BRK]  = drive_reg.break_low;
		stat_word[ofs_pkg::STAT_LAT]  = ov_latched_reg;
		stat_word[ofs_pkg::STAT_SSD]  = drive_reg.ss_discharge;
		stat_word[ofs_pkg::STAT_LIMP] = sense.limp_home;
		stat_word[ofs_pkg::STAT_DIM +: 8] = analog_dim_input;
	end

	always_comb begin
		short_threshold_code_next = short_threshold_code_reg;
		overvoltage_latch_enable_next = overvoltage_latch_enable_reg;
		rdata_next = 32'h00000000;
		if (wr) begin
			case (addr)
				ofs_pkg::ADDR_MFS: begin
					short_threshold_code_next = wdata[3:0];
				end
				ofs_pkg::ADDR_SWT: begin
					overvoltage_latch_enable_next =
						wdata[ofs_pkg::SWT_OVLAT];
				end
				default: begin
				end
			endcase
		end
		if (rd) begin
			case (addr)
				ofs_pkg::ADDR_MFS: begin
					rdata_next = {28'h0000000, short_threshold_code_reg};
				end
				ofs_pkg::ADDR_SWT: begin
					rdata_next = {31'h00000000,
						overvoltage_latch_enable_reg};
				end
				ofs_pkg::ADDR_DIAG: begin
					rdata_next = {28'h0000000, diag_reg};
				end
				ofs_pkg::ADDR_STAT: begin
					rdata_next = stat_word;
				end
				default: begin
					rdata_next = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			short_threshold_code_reg     <= ofs_pkg::THR_CODE_RST;
			overvoltage_latch_enable_reg <= 1'b0;
			rdata_reg                    <= 32'h00000000;
		end else if (ce) begin
			short_threshold_code_reg     <= short_threshold_code_next;
			overvoltage_latch_enable_reg <= overvoltage_latch_enable_next;
			rdata_reg                    <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Fault detection and flags
	// ----------------------------------------------------------------
	assign short_cond = sense.ss_ready && sense.fb_below_short; // see R4
	assign short_det  = short_cond
		&& (short_cnt_reg == ofs_pkg::SHORT_LAST);           // see R19
	assign ol_raw = sense.fb_above_ol && sense.cs_below_ol_ref; // see R10
	assign ol_det = ol_raw && sense.ss_ready;                 // see R11
	assign ov_det = sense.fb_over_ov;
	assign ov_hold = ov_det || ov_latched_reg;                 // see R9

	always_comb begin
		set_vec = '0;
		set_vec[ofs_pkg::DG_SHORT] = short_det;               // see R20
		set_vec[ofs_pkg::DG_OV]    = ov_det;                  // see R6
		set_vec[ofs_pkg::DG_OL]    = ol_det;                  // see R12
		set_vec[ofs_pkg::DG_VIN]   = sense.input_ov_sense;    // see R16
	end

	always_comb begin
		short_cnt_next = 3'h0;
		if (short_cond && (short_cnt_reg != ofs_pkg::SHORT_LAST)) begin
			short_cnt_next = short_cnt_reg + 3'h1;
		end else if (short_cond) begin
			short_cnt_next = short_cnt_reg;
		end
		// Flags hold until read or, for OV, a clear-latch write; latched OV survives the read
		diag_next = diag_reg;                                 // see R21
		if (rd_diag) begin
			diag_next = '0;                               // see R8, R13
			diag_next[ofs_pkg::DG_OV] = diag_reg[ofs_pkg::DG_OV]
				&& ov_latched_reg;
		end
		if (clear_latch_control) begin
			diag_next[ofs_pkg::DG_OV] = 1'b0;                 // see R9
		end
		diag_next = diag_next | set_vec;                      // see R14
		ov_latched_next = ov_latched_reg;
		if (ov_det && overvoltage_latch_enable_reg) begin
			ov_latched_next = 1'b1;                           // see R9
		end else if (clear_latch_control) begin
			ov_latched_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			short_cnt_reg  <= 3'h0;
			diag_reg       <= '0;
			ov_latched_reg <= 1'b0;
		end else if (ce) begin
			short_cnt_reg  <= short_cnt_next;
			diag_reg       <= diag_next;
			ov_latched_reg <= ov_latched_next;
		end
	end

	// ----------------------------------------------------------------
	// Supervisor state machine and drive
	// ----------------------------------------------------------------
	// Comparator outputs already carry hysteresis, taken as levels
	assign fault_now = short_det || ov_hold || ol_det
		|| sense.input_ov_sense;                              // see R18
	assign release_ok = !short_cond && !ov_hold && !ol_raw
		&& !sense.input_ov_sense;                         // see R7, R17

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ofs_pkg::st_idle: begin
				if (sense.enable_uv_sense && fault_now) begin // see R18
					state_next = ofs_pkg::st_stop;           // see R6
				end else if (sense.enable_uv_sense) begin
					state_next = ofs_pkg::st_soft;
				end
			end
			ofs_pkg::st_soft: begin
				if (!sense.enable_uv_sense) begin
					state_next = ofs_pkg::st_idle;
				end else if (fault_now) begin
					state_next = ofs_pkg::st_stop;
				end else if (sense.ss_ready) begin
					state_next = ofs_pkg::st_run;
				end
			end
			ofs_pkg::st_run: begin
				if (!sense.enable_uv_sense) begin
					state_next = ofs_pkg::st_idle;
				end else if (fault_now) begin
					state_next = ofs_pkg::st_stop;        // see R6, R12
				end
			end
			ofs_pkg::st_stop: begin
				if (!sense.enable_uv_sense) begin
					state_next = ofs_pkg::st_idle;
				end else if (release_ok) begin
					state_next = ofs_pkg::st_soft;   // see R5, R12, R17
				end
			end
			default: begin
				state_next = ofs_pkg::st_idle;
			end
		endcase
		drive_next.break_low = (state_next == ofs_pkg::st_idle)
			|| (state_next == ofs_pkg::st_stop);                // see R6
		drive_next.ss_discharge = drive_next.break_low
			|| sense.input_ov_sense;                           // see R16
		drive_next.comp_discharge = ol_raw;                    // see R15
		// Dimming input takes no part in the threshold
		drive_next.short_thr_mv = sense.limp_home
			? thr_mv(ofs_pkg::THR_CODE_RST)                     // see R2
			: thr_mv(short_threshold_code_reg);            // see R1, R3
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg                <= ofs_pkg::st_idle;
			drive_reg.break_low      <= 1'b1;
			drive_reg.ss_discharge   <= 1'b1;
			drive_reg.comp_discharge <= 1'b0;
			drive_reg.short_thr_mv   <= ofs_pkg::THR_DEF_MV;
		end else if (ce) begin
			state_reg <= state_next;
			drive_reg <= drive_next;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_low8;
		(ce && sense.ss_ready && sense.fb_below_short)[*8];
	endsequence

	sequence s_ol_seen;
		ce && sense.ss_ready && sense.fb_above_ol && sense.cs_below_ol_ref;
	endsequence

	a_short_filter: assert property (@(posedge clk) disable iff (srst)
		s_low8 |=> diag_reg[ofs_pkg::DG_SHORT] && drive.break_low) // see R19
		else $error("short not flagged after eight low cycles");

	a_short_early: assert property (@(posedge clk) disable iff (srst)
		ce && $rose(diag_reg[ofs_pkg::DG_SHORT]) |->
		$past(short_cnt_reg) == ofs_pkg::SHORT_LAST)          // see R20
		else $error("short flagged before filter elapsed");

	a_mask_ramp: assert property (@(posedge clk) disable iff (srst || !ce)
		!sense.ss_ready |=> !$rose(diag_reg[ofs_pkg::DG_SHORT])
		&& !$rose(diag_reg[ofs_pkg::DG_OL]))                  // see R4, R11
		else $error("detection not masked during ramp");

	a_ov_stop: assert property (@(posedge clk) disable iff (srst || !ce)
		sense.fb_over_ov && sense.enable_uv_sense |=>
		diag_reg[ofs_pkg::DG_OV] && drive.break_low)             // see R6
		else $error("overvoltage did not stop gates");

	a_ov_latch_hold: assert property (@(posedge clk)
		disable iff (srst || !ce)
		ov_latched_reg && !clear_latch_control |=>
		drive.break_low && diag_reg[ofs_pkg::DG_OV])             // see R9
		else $error("latched overvoltage released early");

	a_read_clear: assert property (@(posedge clk) disable iff (srst || !ce)
		rd_diag && set_vec == '0 && !ov_latched_reg |=>
		diag_reg == '0)                                     // see R8, R13
		else $error("diagnosis read did not clear flags");

	a_ol_stop: assert property (@(posedge clk) disable iff (srst || !ce)
		s_ol_seen ##0 sense.enable_uv_sense |=>
		diag_reg[ofs_pkg::DG_OL] && drive.break_low)       // see R10, R12
		else $error("open load not flagged or not stopped");

	a_comp_dis: assert property (@(posedge clk) disable iff (srst || !ce)
		##1 drive.comp_discharge == $past(ol_raw))              // see R15
		else $error("compensation discharge wrong");

	a_vin_ov: assert property (@(posedge clk) disable iff (srst || !ce)
		sense.input_ov_sense |=> diag_reg[ofs_pkg::DG_VIN]
		&& drive.ss_discharge)                                  // see R16
		else $error("input overvoltage not handled");

	a_restart_soft: assert property (@(posedge clk)
		disable iff (srst || !ce)
		state_reg == ofs_pkg::st_stop && release_ok
		&& sense.enable_uv_sense |=> state_reg == ofs_pkg::st_soft
		&& !drive.break_low && !drive.ss_discharge)     // see R5, R7, R17
		else $error("no soft start after fault cleared");

	a_limp_thr: assert property (@(posedge clk) disable iff (srst || !ce)
		sense.limp_home |=> drive.short_thr_mv == ofs_pkg::THR_DEF_MV) // see R2
		else $error("limp-home threshold not default");

	a_multi_flags: assert property (@(posedge clk)
		disable iff (srst || !ce)
		set_vec != '0 |=> (diag_reg & $past(set_vec)) == $past(set_vec)) // see R14
		else $error("a fault flag was masked");

	a_short_count: assert property (@(posedge clk) // see R19
		disable iff (srst || !ce)
		!(sense.ss_ready && sense.fb_below_short) |=> short_cnt_reg == 3'h0)
		else $error("short filter not restarted");

	a_flag_hold: assert property (@(posedge clk) // see R21
		disable iff (srst || !ce)
		!rd_diag && !clear_latch_control |=>
		(diag_reg & $past(diag_reg)) == $past(diag_reg))
		else $error("fault flag dropped without a read");

	a_dim_indep: assert property (@(posedge clk) // see R3
		disable iff (srst || !ce)
		$changed(analog_dim_input) && $stable(short_threshold_code_reg)
		&& $stable(sense.limp_home) |=> $stable(drive.short_thr_mv))
		else $error("dimming input moved the short threshold");

	a_idle_fault: assert property (@(posedge clk) // see R16
		disable iff (srst || !ce)
		state_reg == ofs_pkg::st_idle && sense.enable_uv_sense
		&& sense.input_ov_sense |=> state_reg == ofs_pkg::st_stop)
		else $error("enable during a fault started switching");

endmodule // ofs_supervisor

// File: tb/ofs_host_model.sv
/*
 * Host model: register master of the fault supervisor, driving the plain
 * strobe bus. Assumes rdata stands only in the cycle after the read strobe.
 */
`timescale 1ns/100ps
module ofs_host_model (
	input  wire logic        clk,   // System clock
	output      logic [7:0]  addr,  // Register address
	output      logic [31:0] wdata, // Write data
	output      logic        wr,    // Write strobe
	output      logic        rd,    // Read strobe
	input  wire logic [31:0] rdata  // Read data
);
	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------
	initial begin
		addr  = 8'h00;
		wdata = 32'h0;
		wr    = 1'b0;
		rd    = 1'b0;
	end

	// Also used to pulse the latch clear bit
	task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		wdata <= ~d;
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
endmodule // ofs_host_model

// File: tb/ofs_supervisor_tb.sv
/*
 * Self-checking testbench of the output fault supervisor.
 * Assumes the host model for register access and drives the comparator
 * results itself at the rising edge.
 */
`timescale 1ns/100ps
module ofs_supervisor_tb;
	logic                clk;
	logic                srst;
	logic                ce;
	logic [7:0]          addr;
	logic [31:0]         wdata;
	logic                wr;
	logic                rd;
	logic [31:0]         rdata;
	ofs_pkg::ofs_sense_t sen;
	logic [7:0]          dim;
	ofs_pkg::ofs_drive_t drv;
	int                  error_cnt;
	int                  cmp_count;
	logic [31:0]         expv;

	ofs_supervisor ofs_supervisor_i (
		.clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .sense(sen),
		.analog_dim_input(dim), .drive(drv)
	);

	ofs_host_model ofs_host_model_i (
		.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata)
	);

	// ----------------------------------------------------------------
	// Clock, helpers
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		ofs_host_model_i.read_reg(a, v);
		chk(v, exp);
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		ofs_host_model_i.write_reg(a, d);
	endtask

	// Soft-start ramp drops and rises again
	task automatic ramp();
		@(posedge clk);
		sen.ss_ready <= 1'b0;
		cyc(3);
		sen.ss_ready <= 1'b1;
		cyc(4);
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		cyc(20000);
		error_cnt++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		error_cnt = 0;
		cmp_count = 0;
		sen = '0;
		dim = 8'h00;
		ce = 1'b1;
		srst = 1'b1;
		cyc(16);
		srst <= 1'b0;
		cyc(1);
		chk({31'h0, drv.break_low}, 32'h1);
		chk({31'h0, drv.ss_discharge}, 32'h1);
		rchk(ofs_pkg::ADDR_MFS, 32'h8);
		rchk(ofs_pkg::ADDR_SWT, 32'h0);
		rchk(ofs_pkg::ADDR_DIAG, 32'h0);
		rchk(8'h20, 32'h0);
		$display("test reset done");

		for (int c = 0; c < 16; c++) begin
			wreg(ofs_pkg::ADDR_MFS, 32'(c));
			cyc(2);
			expv = (c == 0) ? 32'd1163 : 32'(38 + 75 * (c - 1));
			chk({21'h0, drv.short_thr_mv}, expv);
		end
		rchk(ofs_pkg::ADDR_MFS, 32'hf);
		wreg(ofs_pkg::ADDR_MFS, 32'hc);
		cyc(3);
		chk({21'h0, drv.short_thr_mv}, 32'd863);
		dim <= 8'hff;
		cyc(3);
		chk({21'h0, drv.short_thr_mv}, 32'd863);
		sen.limp_home <= 1'b1;
		cyc(3);
		chk({21'h0, drv.short_thr_mv}, 32'd563);
		sen.limp_home <= 1'b0;
		$display("test threshold done");

		sen.enable_uv_sense <= 1'b1;
		cyc(4);
		sen.fb_below_short <= 1'b1;
		sen.fb_above_ol <= 1'b1;
		sen.cs_below_ol_ref <= 1'b1;
		cyc(12);
		chk({31'h0, drv.comp_discharge}, 32'h1);
		sen <= 8'h02;
		rchk(ofs_pkg::ADDR_DIAG, 32'h0);
		ramp();
		chk({31'h0, drv.break_low}, 32'h0);
		$display("test masking done");

		sen.fb_below_short <= 1'b1;
		cyc(7);
		sen.fb_below_short <= 1'b0;
		cyc(3);
		rchk(ofs_pkg::ADDR_DIAG, 32'h0);
		sen.fb_below_short <= 1'b1;
		cyc(11);
		chk({31'h0, drv.break_low}, 32'h1);
		sen.fb_below_short <= 1'b0;
		ramp();
		chk({31'h0, drv.break_low}, 32'h0);
		rchk(ofs_pkg::ADDR_DIAG, 32'h1);
		rchk(ofs_pkg::ADDR_DIAG, 32'h0);
		$display("test short done");

		sen.fb_over_ov <= 1'b1;
		sen.fb_above_ol <= 1'b1;
		sen.cs_below_ol_ref <= 1'b1;
		cyc(3);
		chk({31'h0, drv.break_low}, 32'h1);
		chk({31'h0, drv.comp_discharge}, 32'h1);
		sen <= 8'h02;
		ramp();
		chk({31'h0, drv.break_low}, 32'h0);
		chk({31'h0, drv.comp_discharge}, 32'h0);
		rchk(ofs_pkg::ADDR_DIAG, 32'h6);
		rchk(ofs_pkg::ADDR_DIAG, 32'h0);
		$display("test overvoltage open load done");

		wreg(ofs_pkg::ADDR_SWT, 32'h1);
		rchk(ofs_pkg::ADDR_SWT, 32'h1);
		sen.fb_over_ov <= 1'b1;
		cyc(2);
		sen.fb_over_ov <= 1'b0;
		ramp();
		chk({31'h0, drv.break_low}, 32'h1);
		rchk(ofs_pkg::ADDR_DIAG, 32'h2);
		rchk(ofs_pkg::ADDR_DIAG, 32'h2);
		rchk(ofs_pkg::ADDR_STAT, 32'h0000ff07);
		wreg(ofs_pkg::ADDR_CTRL, 32'h1);
		ramp();
		chk({31'h0, drv.break_low}, 32'h0);
		rchk(ofs_pkg::ADDR_DIAG, 32'h0);
		rchk(ofs_pkg::ADDR_CTRL, 32'h0);
		wreg(ofs_pkg::ADDR_SWT, 32'h0);
		$display("test latched overvoltage done");

		sen.input_ov_sense <= 1'b1;
		cyc(3);
		chk({31'h0, drv.ss_discharge}, 32'h1);
		sen.input_ov_sense <= 1'b0;
		ramp();
		chk({31'h0, drv.ss_discharge}, 32'h0);
		chk({31'h0, drv.break_low}, 32'h0);
		rchk(ofs_pkg::ADDR_DIAG, 32'h8);
		sen.enable_uv_sense <= 1'b0;
		cyc(3);
		chk({31'h0, drv.break_low}, 32'h1);
		sen.enable_uv_sense <= 1'b1;
		sen.input_ov_sense <= 1'b1;
		cyc(3);
		chk({31'h0, drv.break_low}, 32'h1);
		sen.input_ov_sense <= 1'b0;
		cyc(3);
		chk({31'h0, drv.break_low}, 32'h0);
		ce <= 1'b0;
		wreg(ofs_pkg::ADDR_MFS, 32'h3);
		ce <= 1'b1;
		rchk(ofs_pkg::ADDR_MFS, 32'hc);
		$display("test input voltage done");
		complete_run();
	end
endmodule // ofs_supervisor_tb
